//--- logic/hpp_map.svh
// Register map, field positions, reset values and timing counts of the host port
`ifndef HPP_MAP_SVH
`define HPP_MAP_SVH
// ****************
// Offsets
// ****************
`define HPP_OFF_DATA      8'h08
`define HPP_OFF_PORT      8'h09
`define HPP_OFF_IRQF      8'h0C
`define HPP_OFF_DIR       8'h89
`define HPP_OFF_IRQE      8'h8C
`define HPP_OFF_ANALOG    8'h9F
`define HPP_OFF_DDIR      8'h88
// ****************
// Fields and resets
// ****************
`define HPP_BIT_IN_FULL   7
`define HPP_BIT_OUT_FULL  6
`define HPP_BIT_IN_OVR    5
`define HPP_BIT_MODE      4
`define HPP_BIT_UNUSED    3
`define HPP_DIR_MSB       2
`define HPP_BIT_PORT_IRQ  7
`define HPP_PIN_RD        0
`define HPP_PIN_WR        1
`define HPP_PIN_CS        2
`define HPP_DATA_W        8
`define HPP_CTL_W         3
`define HPP_RST_DIR       3'h7
`define HPP_RST_SYNC      3'h7
`define HPP_RST_DDIR      8'hFF
`define HPP_RST_ZERO8     8'h00
`define HPP_DIR_WMASK     8'h37
`define HPP_ANALOG_WMASK  8'h8F
// ****************
// Phase timing
// ****************
`define HPP_PH_STEP       2'h1
`define HPP_PH_TWO        2'h1
`define HPP_PH_FOUR       2'h3
`endif

//--- logic/hpp_pkg.sv
// Types of the host parallel port
package hpp_pkg;
  typedef enum logic [1:0] {
    HPP_IDLE  = 2'b00,
    HPP_WAIT2 = 2'b01,
    HPP_WAIT4 = 2'b10
  } hpp_done_t;

  typedef struct packed {
    logic [1:0]  phase;
    logic [2:0]  rd_sync;
    logic [2:0]  wr_sync;
    logic [2:0]  cs_sync;
    logic        wr_act;
    logic        rd_act;
    hpp_done_t   wr_done;
    hpp_done_t   rd_done;
    logic [7:0]  in_latch;
    logic [7:0]  out_latch;
    logic [7:0]  data_dir;
    logic [2:0]  ctl_out;
    logic [2:0]  ctl_dir;
    logic        mode;
    logic        inbound_full;
    logic        outbound_full;
    logic        inbound_overrun;
    logic [7:0]  irq_flags;
    logic [7:0]  irq_en;
    logic [7:0]  analog;
    logic [7:0]  rdata;
  } hpp_state_t;
endpackage

//--- logic/hpp_top.sv
// Host parallel slave port: register file, strobe sync and flag sequencing
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "hpp_map.svh"
module hpp_top (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] data_pin_in,
  output logic      [7:0] data_pin_out,
  output logic      [7:0] data_pin_oe,
  input  wire logic [2:0] ctl_pin_in,
  output logic      [2:0] ctl_pin_out,
  output logic      [2:0] ctl_pin_oe,
  output logic            irq_req
);
  // ****************
  // Declarations
  // ****************
  hpp_pkg::hpp_state_t s_reg;
  hpp_pkg::hpp_state_t s_next;
  logic                rd_low;
  logic                wr_low;
  logic                cs_low;
  logic                pin_wr_low;
  logic                host_reading;
  genvar               gi;

  // ****************
  // Address decode
  // ****************
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] offset);
    return addr == offset;
  endfunction

  // ****************
  // Synchroniser step
  // ****************
  function automatic logic [2:0] sync_shift(input logic [2:0] chain,
                                            input logic       pin);
    return {chain[1:0], pin};
  endfunction

  // ****************
  // Completion sequencer: phase two then phase four
  // ****************
  function automatic hpp_pkg::hpp_done_t done_step(input hpp_pkg::hpp_done_t st,
                                                   input logic [1:0]         ph);
    hpp_pkg::hpp_done_t r;
    r = st;
    unique case (st)
      hpp_pkg::HPP_IDLE: begin
        r = hpp_pkg::HPP_IDLE;
      end
      hpp_pkg::HPP_WAIT2: begin
        if (ph == `HPP_PH_TWO) begin
          r = hpp_pkg::HPP_WAIT4;
        end
      end
      hpp_pkg::HPP_WAIT4: begin
        if (ph == `HPP_PH_FOUR) begin
          r = hpp_pkg::HPP_IDLE;
        end
      end
      default: begin
        r = hpp_pkg::HPP_IDLE;
      end
    endcase
    return r;
  endfunction

  function automatic logic done_fire(input hpp_pkg::hpp_done_t st,
                                     input logic [1:0]         ph);
    return (st == hpp_pkg::HPP_WAIT4) && (ph == `HPP_PH_FOUR);
  endfunction

  // ****************
  // Status byte
  // ****************
  function automatic logic [7:0] status_byte(input hpp_pkg::hpp_state_t st);
    logic [7:0] r;
    r = `HPP_RST_ZERO8;
    r[`HPP_BIT_IN_FULL]  = st.inbound_full;
    r[`HPP_BIT_OUT_FULL] = st.outbound_full;
    r[`HPP_BIT_IN_OVR]   = st.inbound_overrun;
    r[`HPP_BIT_MODE]     = st.mode;
    // Unimplemented bit reads zero
    r[`HPP_BIT_UNUSED]   = 1'b0;
    r[`HPP_DIR_MSB:0]    = st.ctl_dir;
    return r;
  endfunction

  // ****************
  // Register read
  // ****************
  function automatic logic [7:0] read_value(input logic [7:0]          addr,
                                            input hpp_pkg::hpp_state_t st,
                                            input logic [7:0]          pins,
                                            input logic [2:0]          ctl);
    logic [7:0] r;
    r = `HPP_RST_ZERO8;
    unique case (addr)
      `HPP_OFF_DATA: begin
        r = st.mode ? st.in_latch : pins;
      end
      `HPP_OFF_PORT: begin
        r = {5'h00, ctl};
      end
      `HPP_OFF_IRQF: begin
        r = st.irq_flags;
      end
      `HPP_OFF_DIR: begin
        r = status_byte(st);
      end
      `HPP_OFF_IRQE: begin
        r = st.irq_en;
      end
      `HPP_OFF_ANALOG: begin
        r = st.analog;
      end
      `HPP_OFF_DDIR: begin
        r = st.data_dir;
      end
      default: begin
        r = `HPP_RST_ZERO8;
      end
    endcase
    return r;
  endfunction

  // ****************
  // Strobe detection
  // ****************
  // Detection uses the last synchroniser stage only
  assign rd_low       = ~s_reg.rd_sync[2];
  assign wr_low       = ~s_reg.wr_sync[2];
  assign cs_low       = ~s_reg.cs_sync[2];
  assign host_reading = cs_low && rd_low;
  // Raw pins frame the capture, so the sync delay never sees a released bus
  assign pin_wr_low   = !ctl_pin_in[`HPP_PIN_CS] && !ctl_pin_in[`HPP_PIN_WR];

  // ****************
  // Next state
  // ****************
  always_comb begin
    logic wr_start;
    logic rd_start;
    logic wr_end;
    logic rd_end;
    logic sw_rd_data;
    logic sw_wr_data;
    wr_start       = 1'b0;
    rd_start       = 1'b0;
    wr_end         = 1'b0;
    rd_end         = 1'b0;
    sw_rd_data     = reg_rd && addr_hit(reg_addr, `HPP_OFF_DATA);
    sw_wr_data     = reg_wr && addr_hit(reg_addr, `HPP_OFF_DATA);
    s_next         = s_reg;
    s_next.phase   = s_reg.phase + `HPP_PH_STEP;
    s_next.rd_sync = sync_shift(s_reg.rd_sync, ctl_pin_in[`HPP_PIN_RD]);
    s_next.wr_sync = sync_shift(s_reg.wr_sync, ctl_pin_in[`HPP_PIN_WR]);
    s_next.cs_sync = sync_shift(s_reg.cs_sync, ctl_pin_in[`HPP_PIN_CS]);

    // ****************
    // Transfer tracking
    // ****************
    if (s_reg.mode) begin
      wr_start = cs_low && wr_low && !s_reg.wr_act;
      rd_start = host_reading && !s_reg.rd_act;
    end
    wr_end = s_reg.wr_act && !(cs_low && wr_low);
    rd_end = s_reg.rd_act && !host_reading;
    if (wr_start) begin
      s_next.wr_act = 1'b1;
    end else if (wr_end) begin
      s_next.wr_act = 1'b0;
    end
    if (rd_start) begin
      s_next.rd_act = 1'b1;
    end else if (rd_end) begin
      s_next.rd_act = 1'b0;
    end

    // ****************
    // Byte capture
    // ****************
    // Bus byte follows the pins for as long as select and write stay low
    if (s_reg.mode && pin_wr_low) begin
      s_next.in_latch = data_pin_in;
    end

    // ****************
    // Completion timing
    // ****************
    // End seen here; flags follow the next phase two, then phase four
    if (wr_end) begin
      s_next.wr_done = hpp_pkg::HPP_WAIT2;
    end else begin
      s_next.wr_done = done_step(s_reg.wr_done, s_reg.phase);
    end
    if (rd_end) begin
      s_next.rd_done = hpp_pkg::HPP_WAIT2;
    end else begin
      s_next.rd_done = done_step(s_reg.rd_done, s_reg.phase);
    end

    // ****************
    // Software writes
    // ****************
    if (reg_wr) begin
      unique case (reg_addr)
        `HPP_OFF_DATA: begin
          s_next.out_latch = reg_wdata;
        end
        `HPP_OFF_PORT: begin
          s_next.ctl_out = reg_wdata[`HPP_DIR_MSB:0];
        end
        `HPP_OFF_IRQF: begin
          s_next.irq_flags = reg_wdata;
        end
        `HPP_OFF_DIR: begin
          s_next.ctl_dir = reg_wdata[`HPP_DIR_MSB:0];
          s_next.mode    = reg_wdata[`HPP_BIT_MODE];
          if (!reg_wdata[`HPP_BIT_IN_OVR]) begin
            s_next.inbound_overrun = 1'b0;
          end
        end
        `HPP_OFF_IRQE: begin
          s_next.irq_en = reg_wdata;
        end
        `HPP_OFF_ANALOG: begin
          s_next.analog = reg_wdata & `HPP_ANALOG_WMASK;
        end
        `HPP_OFF_DDIR: begin
          s_next.data_dir = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    // ****************
    // Outbound flag
    // ****************
    if (sw_wr_data) begin
      s_next.outbound_full = 1'b1;
    end
    if (rd_start) begin
      s_next.outbound_full = 1'b0;
    end

    // ****************
    // Inbound flags
    // ****************
    // Hardware set wins over a software clear in the same cycle
    if (sw_rd_data) begin
      s_next.inbound_full = 1'b0;
    end
    if (done_fire(s_reg.wr_done, s_reg.phase)) begin
      if (s_reg.inbound_full) begin
        s_next.inbound_overrun = 1'b1;
      end
      s_next.inbound_full = 1'b1;
      s_next.irq_flags[`HPP_BIT_PORT_IRQ] = 1'b1;
    end
    if (done_fire(s_reg.rd_done, s_reg.phase)) begin
      s_next.irq_flags[`HPP_BIT_PORT_IRQ] = 1'b1;
    end

    // ****************
    // Mode gating
    // ****************
    if (!s_next.mode) begin
      s_next.inbound_full  = 1'b0;
      s_next.outbound_full = 1'b0;
    end

    // ****************
    // Read data
    // ****************
    // Answer stands only in the cycle after the strobe
    s_next.rdata = `HPP_RST_ZERO8;
    if (reg_rd) begin
      s_next.rdata = read_value(reg_addr, s_reg, data_pin_in, ctl_pin_in);
    end
  end

  // ****************
  // State register
  // ****************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_reg          <= '0;
      s_reg.rd_sync  <= `HPP_RST_SYNC;
      s_reg.wr_sync  <= `HPP_RST_SYNC;
      s_reg.cs_sync  <= `HPP_RST_SYNC;
      s_reg.data_dir <= `HPP_RST_DDIR;
      s_reg.ctl_dir  <= `HPP_RST_DIR;
      s_reg.wr_done  <= hpp_pkg::HPP_IDLE;
      s_reg.rd_done  <= hpp_pkg::HPP_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************
  // Register outputs
  // ****************
  assign reg_rdata    = s_reg.rdata;
  assign data_pin_out = s_reg.out_latch;
  assign ctl_pin_out  = s_reg.ctl_out;

  // ****************
  // Interrupt request
  // ****************
  assign irq_req = s_reg.irq_flags[`HPP_BIT_PORT_IRQ] &&
                   s_reg.irq_en[`HPP_BIT_PORT_IRQ];

  // ****************
  // Data pin direction
  // ****************
  // Slave mode: drive only while the host reads with select low
  generate
    for (gi = 0; gi < `HPP_DATA_W; gi++) begin : g_data_oe
      assign data_pin_oe[gi] = s_reg.mode ? host_reading : ~s_reg.data_dir[gi];
    end
  endgenerate

  // ****************
  // Control pin direction
  // ****************
  // A set direction bit makes its pin an input
  generate
    for (gi = 0; gi < `HPP_CTL_W; gi++) begin : g_ctl_oe
      assign ctl_pin_oe[gi] = ~s_reg.ctl_dir[gi];
    end
  endgenerate
endmodule // hpp_top

//--- tb/hpp_props.sv
// Port-level checker of the host parallel port
`timescale 1ns/1ps
module hpp_props (
  input logic       clk_sys,
  input logic       rstn,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic [7:0] data_pin_out,
  input logic [7:0] data_pin_oe,
  input logic [2:0] ctl_pin_in,
  input logic [2:0] ctl_pin_oe,
  input logic       irq_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ****************
  // Cycles since select was last low
  // ****************
  logic [4:0] cs_idle_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn || !ctl_pin_in[2]) cs_idle_reg <= 5'h00;
    else if (cs_idle_reg != 5'h1F) cs_idle_reg <= cs_idle_reg + 5'h01;
  end
  // ****************
  // Assertions
  // ****************
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_out_latch: assert property ($past(reg_wr && reg_addr == 8'h08) |->
    data_pin_out == $past(reg_wdata))
    else $error("outbound latch not loaded");
  a_dir_bit3: assert property (reg_rd && reg_addr == 8'h89 |=> reg_rdata[3] == 1'b0)
    else $error("unused status bit not zero");
  a_ctl_dir: assert property ($past(reg_wr && reg_addr == 8'h89) |->
    ctl_pin_oe == ~$past(reg_wdata[2:0]))
    else $error("control pin direction wrong");
  a_oe_read: assert property ($rose(data_pin_oe[0]) && !$past(reg_wr) |->
    !$past(ctl_pin_in[0], 2) && !$past(ctl_pin_in[2], 2))
    else $error("data bus driven without read");
  a_oe_release: assert property ($fell(data_pin_oe[0]) && !$past(reg_wr) |->
    $past(ctl_pin_in[0], 2) || $past(ctl_pin_in[2], 2))
    else $error("data bus released during read");
  a_irq_cause: assert property ($rose(irq_req) |-> $past(reg_wr) || cs_idle_reg < 5'h14)
    else $error("interrupt raised without cause");
  c_write: cover property (ctl_pin_in == 3'b001);
  c_read: cover property (ctl_pin_in == 3'b010);
  c_irq: cover property ($rose(irq_req));
endmodule // hpp_props

bind hpp_top hpp_props u_props (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .ctl_pin_in(ctl_pin_in),
  .ctl_pin_oe(ctl_pin_oe), .irq_req(irq_req));

//--- tb/hpp_host_model.sv
// Behavioural external microprocessor on the host data bus
`timescale 1ns/1ps
module hpp_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] bus_in,
  output logic      [2:0] ctl_n,
  output logic      [7:0] bus_drv,
  output logic      [7:0] rd_byte
);
  initial begin
    ctl_n = 3'h7;
    bus_drv = 8'hA5;
    rd_byte = 8'h00;
  end
  // Strobe low len cycles, then a long idle; released bus flips
  task automatic xfer(input logic wr, input logic [7:0] d, input int len);
    @(posedge clk_sys);
    ctl_n <= {1'b0, !wr, wr};
    bus_drv <= wr ? d : ~bus_drv;
    repeat (len) @(posedge clk_sys);
    rd_byte = bus_in;
    ctl_n <= 3'h7;
    bus_drv <= ~bus_drv;
    repeat (16) @(posedge clk_sys);
  endtask
endmodule // hpp_host_model

//--- tb/tb_top.sv
// Self-checking bench of the host parallel port
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata, dout, doe, hbus, rbyte;
  logic [2:0] cout, coe, hctl;
  logic       irq_req;
  int         bad_count = 0;
  int         n_checks = 0;
  wire [7:0]  dbus = (doe & dout) | (~doe & hbus);
  wire [2:0]  cbus = (coe & cout) | (~coe & hctl);
  always #5 clk_sys = ~clk_sys;
  hpp_top dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_pin_in(dbus),
    .data_pin_out(dout), .data_pin_oe(doe), .ctl_pin_in(cbus), .ctl_pin_out(cout),
    .ctl_pin_oe(coe), .irq_req(irq_req));
  hpp_host_model host (.clk_sys(clk_sys), .bus_in(dbus), .ctl_n(hctl), .bus_drv(hbus),
    .rd_byte(rbyte));
  // ****************
  // Register bus tasks
  // ****************
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rchk(8'h89, 8'h07);
    rchk(8'h0C, 8'h00);
    rchk(8'h8C, 8'h00);
    rchk(8'h9F, 8'h00);
    rchk(8'h01, 8'h00);
    $display("done t_reset");
  endtask
  task automatic t_host_write;
    wreg(8'h9F, 8'h06);
    wreg(8'h89, 8'h17);
    wreg(8'h8C, 8'h80);
    host.xfer(1'b1, 8'h3C, 3);
    rchk(8'h89, 8'h97);
    `CHK(irq_req, 1'b1)
    host.xfer(1'b1, 8'h5A, 8);
    rchk(8'h89, 8'hB7);
    rchk(8'h08, 8'h5A);
    rchk(8'h89, 8'h37);
    wreg(8'h89, 8'h27);
    rchk(8'h89, 8'h27);
    wreg(8'h89, 8'h07);
    rchk(8'h89, 8'h07);
    wreg(8'h0C, 8'h00);
    `CHK(irq_req, 1'b0)
    $display("done t_host_write");
  endtask
  task automatic t_host_read;
    wreg(8'h89, 8'h17);
    wreg(8'h08, 8'hC3);
    rchk(8'h89, 8'h57);
    host.xfer(1'b0, 8'h00, 8);
    `CHK(rbyte, 8'hC3)
    rchk(8'h89, 8'h17);
    rchk(8'h0C, 8'h80);
    wreg(8'h8C, 8'h00);
    `CHK(irq_req, 1'b0)
    wreg(8'h0C, 8'h00);
    $display("done t_host_read");
  endtask
  task automatic t_no_mode;
    wreg(8'h89, 8'h07);
    host.xfer(1'b1, 8'h99, 3);
    rchk(8'h89, 8'h07);
    rchk(8'h0C, 8'h00);
    $display("done t_no_mode");
  endtask
  task automatic t_ports;
    wreg(8'h88, 8'h0F);
    `CHK(doe, 8'hF0)
    rchk(8'h88, 8'h0F);
    wreg(8'h09, 8'h05);
    wreg(8'h89, 8'h02);
    `CHK(cout, 3'h5)
    `CHK(coe, 3'h5)
    rchk(8'h09, 8'h07);
    wreg(8'h89, 8'h07);
    wreg(8'h88, 8'hFF);
    `CHK(coe, 3'h0)
    `CHK(doe, 8'h00)
    $display("done t_ports");
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_host_write;
    t_host_read;
    t_no_mode;
    t_ports;
    tally_and_finish;
  end
endmodule // tb_top
